/* sfsr_top.sv */
// serial flash slave: status register, write guard and read commands
// What this block does
// R01: status read is answered anytime, even during a running cycle, undisturbed.
// R02: status byte repeats while chip select stays low after status read.
// R03: host should poll busy flag until zero before new commands.
// R04: busy flag reads one during an internal cycle, else zero.
// R05: write-type commands refused while write latch flag is zero.
// R06: busy and latch flags are volatile, read-only, changed by commands/logic.
// R07: protect bits written only by status write; protect area from erase/program.
// R08: bulk erase only if protect bits zero and sector locks not all set.
// R09: lock flag one with guard pin low gives hard protect; status write refused.
// R10: with lock zero or guard high, status write accepted when latch set.
// R11: hard protect entered by either event, left only when guard pin rises.
// R12: host must send write enable before a status write.
// R13: status write is command plus exactly one byte, ending on eighth bit.
// R14: status write keeps b7, b3, b2; b6..b4 read as zero.
// R15: valid status write starts timed cycle; busy held, then busy and latch cleared.
// R16: command and 24-bit address MSB first on rising edges; data out on falling.
// R17: read address increments after each byte and wraps to zero.
// R18: fast read skips one dummy byte before data.
// R19: read ends whenever chip select rises, at any bit.
// R20: array and lock reads rejected while a write cycle runs.
// R21: lock read returns addressed sector lock byte until chip select rises.
// R22: decode status read 05h, status write 01h, write enable 06h.
// R23: decode read 03h, fast read 0Bh, lock read E8h with three address bytes.
// R24: write-type commands need chip select rise on a byte boundary.
// R25: every chip select rise resets bit counter and decoder.
`timescale 1ns/10ps
module sfsr_top
    import sfsr_pkg::*;
#(
    parameter int MEM_AW = 10,
    parameter int SECT_SHIFT = 16,
    parameter int SECT_AW = 2,
    parameter int WRITE_CYC = SFSR_STATUS_WRITE_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // spi pins
    input wire logic i_cs_b,
    input wire logic i_sclk,
    input wire logic i_serial_in_line,
    input wire logic i_write_guard_pin_b,
    output logic o_serial_out_line,
    output logic o_serial_out_oe,
    // busy indication from the unimplemented program and erase engine
    input wire logic i_ext_busy,
    // memory preload ports
    input wire logic i_arr_we,
    input wire logic [MEM_AW-1:0] i_arr_waddr,
    input wire logic [7:0] i_arr_wdata,
    input wire logic i_lock_we,
    input wire logic [SECT_AW-1:0] i_lock_waddr,
    input wire logic [7:0] i_lock_wdata,
    // status and protection views
    output logic [7:0] o_status,
    output logic o_hard_protect_mode,
    output logic o_bulk_erase_ok,
    output logic o_write_latch_flag
);
    // synchronisers
    logic [1:0] cs_s_q, sck_s_q, din_s_q, wg_s_q;
    logic sck_d1_q;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs_s_q <= 2'h3;
            sck_s_q <= 2'h0;
            din_s_q <= 2'h0;
            wg_s_q <= 2'h3;
            sck_d1_q <= 1'b0;
        end else begin
            cs_s_q <= {cs_s_q[0], i_cs_b};
            sck_s_q <= {sck_s_q[0], i_sclk};
            din_s_q <= {din_s_q[0], i_serial_in_line};
            wg_s_q <= {wg_s_q[0], i_write_guard_pin_b};
            sck_d1_q <= sck_s_q[1];
        end
    end

    logic cs_b, sck_rise, sck_fall, din, guard_b;
    logic cs_d1_q;
    logic cs_rise;
    // edge finding on synchronised pins
    always_comb begin
        cs_b = cs_s_q[1];
        din = din_s_q[1];
        guard_b = wg_s_q[1];
        sck_rise = !cs_b && sck_s_q[1] && !sck_d1_q; // R16
        sck_fall = !cs_b && !sck_s_q[1] && sck_d1_q; // R16
        cs_rise = cs_b && !cs_d1_q;
    end

    // frame state
    sfsr_state_t st_q, st_d;
    logic [2:0] bit_q, bit_d;
    logic [2:0] byte_q, byte_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] cmd_q, cmd_d;
    logic [23:0] addr_q, addr_d;
    logic [7:0] out_q, out_d;
    logic oe_q, oe_d;
    logic load_q, load_d;
    logic wr_ok_q, wr_ok_d;
    // status register bits
    logic lock_q, lock_d, wl_q, wl_d;
    logic [1:0] bp_q, bp_d;
    logic [7:0] wdata_q, wdata_d;
    logic busy_q, busy_d;
    logic [31:0] tmr_q, tmr_d;
    logic busy;
    logic hard_protect_mode;
    logic [7:0] status;
    logic [7:0] arr_rdata, lock_rdata;
    logic [7:0] byte_in;

    sfsr_mem #(.AW(MEM_AW), .DW(8)) u_arr (
        .i_clk(i_clk),
        .i_we(i_arr_we),
        .i_waddr(i_arr_waddr),
        .i_wdata(i_arr_wdata),
        .i_raddr(addr_d[MEM_AW-1:0]), // next address, so the load sees its byte
        .o_rdata(arr_rdata)
    );

    sfsr_mem #(.AW(SECT_AW), .DW(8)) u_lock (
        .i_clk(i_clk),
        .i_we(i_lock_we),
        .i_waddr(i_lock_waddr),
        .i_wdata(i_lock_wdata),
        .i_raddr(addr_d[SECT_SHIFT +: SECT_AW]), // R21
        .o_rdata(lock_rdata)
    );

    // status view and protection
    always_comb begin
        busy = busy_q || i_ext_busy; // R04 R06
        hard_protect_mode = lock_q && !guard_b; // R09 R11
        status = 8'h00; // R14
        status[SFSR_BIT_LOCK] = lock_q;
        status[SFSR_BIT_BP_HI] = bp_q[1];
        status[SFSR_BIT_BP_LO] = bp_q[0];
        status[SFSR_BIT_WLATCH] = wl_q;
        status[SFSR_BIT_BUSY] = busy;
        byte_in = {sh_q[6:0], din};
    end

    // command decoder and shifter
    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        byte_d = byte_q;
        sh_d = sh_q;
        cmd_d = cmd_q;
        addr_d = addr_q;
        out_d = out_q;
        oe_d = oe_q;
        load_d = 1'b0;
        wr_ok_d = wr_ok_q;
        wdata_d = wdata_q;
        if (cs_b) begin
            st_d = SFSR_CMD; // R25
            bit_d = 3'h0; // R25
            byte_d = 3'h0;
            oe_d = 1'b0; // R19
            wr_ok_d = 1'b0;
        end else if (sck_rise) begin
            sh_d = byte_in; // R16
            bit_d = bit_q + 3'h1;
            if (bit_q == SFSR_BIT_LAST) begin
                wr_ok_d = 1'b0; // R24
                unique case (st_q)
                    SFSR_CMD: begin
                        cmd_d = byte_in;
                        if (byte_in == SFSR_CMD_WREN) begin // R22
                            wr_ok_d = 1'b1;
                            st_d = SFSR_IGNORE;
                        end else if (byte_in == SFSR_CMD_RDSR) begin // R01 R22
                            st_d = SFSR_SRDATA;
                            load_d = 1'b1;
                        end else if (byte_in == SFSR_CMD_WRSR) begin // R22
                            st_d = SFSR_DATA;
                        end else if ((byte_in == SFSR_CMD_READ || byte_in == SFSR_CMD_FAST
                                      || byte_in == SFSR_CMD_RDLR) && !busy) begin // R20 R23
                            st_d = SFSR_ADDR;
                            byte_d = 3'h0;
                        end else begin
                            st_d = SFSR_IGNORE; // R20
                        end
                    end
                    SFSR_ADDR: begin
                        addr_d = {addr_q[15:0], byte_in}; // R16
                        byte_d = byte_q + 3'h1;
                        if (byte_q + 3'h1 == SFSR_ADDR_BYTES) begin
                            if (cmd_q == SFSR_CMD_FAST) begin
                                st_d = SFSR_DUMMY; // R18
                            end else begin
                                st_d = SFSR_SRDATA;
                                load_d = 1'b1;
                            end
                        end
                    end
                    SFSR_DUMMY: begin
                        st_d = SFSR_SRDATA; // R18
                        load_d = 1'b1;
                    end
                    SFSR_DATA: begin
                        wdata_d = byte_in; // R13
                        wr_ok_d = 1'b1;
                        st_d = SFSR_IGNORE; // R13
                    end
                    SFSR_SRDATA: begin
                        load_d = 1'b1; // R02 R21
                        if (cmd_q == SFSR_CMD_READ || cmd_q == SFSR_CMD_FAST) begin
                            addr_d = addr_q + 24'h1; // R17
                        end
                    end
                    SFSR_IGNORE: begin
                        st_d = SFSR_IGNORE;
                    end
                endcase
            end else if (bit_q == 3'h0) begin
                wr_ok_d = 1'b0; // R13 R24
            end
        end else if (sck_fall && st_q == SFSR_SRDATA) begin
            oe_d = 1'b1; // R16
            // the fall right after a byte load shows its msb, later falls shift
            if (bit_q != 3'h0) begin
                out_d = {out_q[6:0], 1'b0}; // R16
            end
        end
        // byte load one cycle after the decision so memory data is valid
        if (load_q) begin
            if (cmd_q == SFSR_CMD_RDSR) begin
                out_d = status; // R02
            end else if (cmd_q == SFSR_CMD_RDLR) begin
                out_d = lock_rdata; // R21
            end else begin
                out_d = arr_rdata;
            end
        end
    end

    // status register update and self-timed cycle
    always_comb begin
        lock_d = lock_q;
        bp_d = bp_q;
        wl_d = wl_q;
        busy_d = busy_q;
        tmr_d = tmr_q;
        if (busy_q) begin
            if (tmr_q == 32'h0) begin
                busy_d = 1'b0; // R15
                wl_d = 1'b0; // R15
            end else begin
                tmr_d = tmr_q - 32'h1;
            end
        end else if (cs_rise && wr_ok_q && !busy) begin
            if (cmd_q == SFSR_CMD_WREN) begin
                wl_d = 1'b1; // R22 R06
            end else if (cmd_q == SFSR_CMD_WRSR && wl_q && !hard_protect_mode) begin // R05 R09 R10
                lock_d = wdata_q[SFSR_BIT_LOCK]; // R07 R14
                bp_d = {wdata_q[SFSR_BIT_BP_HI], wdata_q[SFSR_BIT_BP_LO]}; // R07
                busy_d = 1'b1; // R15
                tmr_d = 32'(WRITE_CYC - 1);
            end
        end
    end

    // registers
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs_d1_q <= 1'b1;
            st_q <= SFSR_CMD;
            bit_q <= 3'h0;
            byte_q <= 3'h0;
            sh_q <= 8'h00;
            cmd_q <= 8'h00;
            addr_q <= 24'h0;
            out_q <= 8'h00;
            oe_q <= 1'b0;
            load_q <= 1'b0;
            wr_ok_q <= 1'b0;
            wdata_q <= 8'h00;
            lock_q <= SFSR_RST_LOCK;
            bp_q <= SFSR_RST_BP;
            wl_q <= 1'b0;
            busy_q <= 1'b0;
            tmr_q <= 32'h0;
        end else begin
            cs_d1_q <= cs_b;
            st_q <= st_d;
            bit_q <= bit_d;
            byte_q <= byte_d;
            sh_q <= sh_d;
            cmd_q <= cmd_d;
            addr_q <= addr_d;
            out_q <= out_d;
            oe_q <= oe_d;
            load_q <= load_d;
            wr_ok_q <= wr_ok_d;
            wdata_q <= wdata_d;
            lock_q <= lock_d;
            bp_q <= bp_d;
            wl_q <= wl_d;
            busy_q <= busy_d;
            tmr_q <= tmr_d;
        end
    end

    // outputs
    always_comb begin
        o_serial_out_line = out_q[7];
        o_serial_out_oe = oe_q;
        o_status = status;
        o_hard_protect_mode = hard_protect_mode;
        o_bulk_erase_ok = (bp_q == 2'h0) && !(&lock_rdata[1:0]); // R08
        o_write_latch_flag = wl_q; // R05
    end
endmodule // sfsr_top

/* sfsr_pkg.sv */
// package of constants for the serial flash status and read block
package sfsr_pkg;
    // command codes
    localparam logic [7:0] SFSR_CMD_WREN = 8'h06;
    localparam logic [7:0] SFSR_CMD_RDSR = 8'h05;
    localparam logic [7:0] SFSR_CMD_WRSR = 8'h01;
    localparam logic [7:0] SFSR_CMD_READ = 8'h03;
    localparam logic [7:0] SFSR_CMD_FAST = 8'h0B;
    localparam logic [7:0] SFSR_CMD_RDLR = 8'hE8;
    // status register field positions
    localparam int SFSR_BIT_BUSY = 0;
    localparam int SFSR_BIT_WLATCH = 1;
    localparam int SFSR_BIT_BP_LO = 2;
    localparam int SFSR_BIT_BP_HI = 3;
    localparam int SFSR_BIT_LOCK = 7;
    // reset values of the non-volatile bits (delivery state)
    localparam logic SFSR_RST_LOCK = 1'b0;
    localparam logic [1:0] SFSR_RST_BP = 2'h0;
    // bit and byte counts
    localparam logic [2:0] SFSR_BIT_LAST = 3'h7;
    localparam logic [2:0] SFSR_ADDR_BYTES = 3'h3;
    localparam logic [2:0] SFSR_DUMMY_END = 3'h4;
    // status write cycle time in microseconds and clock rate in MHz
    localparam int SFSR_STATUS_WRITE_TIME_US = 15000;
    localparam int SFSR_CLK_MHZ = 125;
    localparam int SFSR_STATUS_WRITE_CYC = SFSR_STATUS_WRITE_TIME_US * SFSR_CLK_MHZ;
    // frame state machine
    typedef enum logic [2:0] {
        SFSR_CMD = 3'b000,
        SFSR_ADDR = 3'b001,
        SFSR_DUMMY = 3'b011,
        SFSR_DATA = 3'b010,
        SFSR_SRDATA = 3'b110,
        SFSR_IGNORE = 3'b111
    } sfsr_state_t;
endpackage

/* sfsr_mem.sv */
// small synchronous read memory holding array bytes or sector lock bytes
`timescale 1ns/10ps
module sfsr_mem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // clock
    input wire logic i_clk,
    // write port, used by integration to preload contents
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    // read port
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // registered read, plain write
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule // sfsr_mem

/* sfsr_chk.sv */
// assertions on the flash status block ports
`timescale 1ns/10ps
module sfsr_chk #(
    parameter int WRITE_CYC = 20
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // watched ports
    input wire logic i_cs_b,
    input wire logic i_write_guard_pin_b,
    input wire logic i_ext_busy,
    input wire logic o_serial_out_oe,
    input wire logic [7:0] o_status,
    input wire logic o_hard_protect_mode,
    input wire logic o_write_latch_flag
);
    logic [31:0] bcnt_q;
    logic [31:0] bcnt_d;
    default clocking dc @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // length of the running busy stretch
    always_comb begin
        bcnt_d = o_status[0] ? bcnt_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bcnt_q <= 32'h0;
        end else begin
            bcnt_q <= bcnt_d;
        end
    end
    AST_ZERO_FIELD: assert property (o_status[6:4] == 3'h0)
        else $error("zero field set");
    AST_LATCH_VIEW: assert property (o_status[1] == o_write_latch_flag)
        else $error("latch view differs");
    AST_HPM_ENTER: assert property ((o_status[7] && !i_write_guard_pin_b) [*5] |-> o_hard_protect_mode)
        else $error("hard protect not entered");
    AST_HPM_LEAVE: assert property (i_write_guard_pin_b [*5] |-> !o_hard_protect_mode)
        else $error("hard protect not left");
    AST_HPM_HOLDS: assert property (o_hard_protect_mode |=> $stable(o_status[7]) && $stable(o_status[3:2]))
        else $error("protect bits moved");
    AST_PROT_LATCH: assert property ($changed(o_status[7:2]) |-> $past(o_write_latch_flag))
        else $error("protect bits moved without latch");
    AST_BUSY_LATCH: assert property ($rose(o_status[0]) && !i_ext_busy |-> $past(o_write_latch_flag))
        else $error("busy without latch");
    AST_EXT_BUSY: assert property (i_ext_busy [*3] |-> o_status[0])
        else $error("external busy not shown");
    AST_OE_IDLE: assert property (i_cs_b [*5] |-> !o_serial_out_oe)
        else $error("output driven while deselected");
    AST_BUSY_LEN: assert property ($fell(o_status[0]) && bcnt_q > 32'h8 |->
        bcnt_q == 32'(WRITE_CYC) ##[0:1] !o_write_latch_flag)
        else $error("write cycle length or latch wrong");
    // main scenarios reached
    cover property ($rose(o_hard_protect_mode));
    cover property ($fell(o_status[0]) && bcnt_q > 32'h8);
    cover property ($rose(o_serial_out_oe));
endmodule // sfsr_chk
bind sfsr_top sfsr_chk #(.WRITE_CYC(WRITE_CYC)) chk_u (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_cs_b(i_cs_b), .i_write_guard_pin_b(i_write_guard_pin_b), .i_ext_busy(i_ext_busy),
    .o_serial_out_oe(o_serial_out_oe), .o_status(o_status),
    .o_hard_protect_mode(o_hard_protect_mode), .o_write_latch_flag(o_write_latch_flag));

/* sfsr_host.sv */
// behavioural spi host driving the flash pins
`timescale 1ns/10ps
module sfsr_host (
    // pacing clock
    input wire logic i_clk,
    // spi pins
    output logic o_cs_b,
    output logic o_sclk,
    output logic o_mosi,
    input wire logic i_miso,
    input wire logic i_miso_oe
);
    logic oe_seen;
    // idle: deselected, clock parked low
    initial begin
        o_cs_b = 1'b1;
        o_sclk = 1'b0;
        o_mosi = 1'b0;
        oe_seen = 1'b0;
    end
    // n clocks, then just past the edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic sel();
        tick(1);
        o_cs_b = 1'b0;
        oe_seen = 1'b0;
        tick(8);
        #0.25; // link edges kept off the system clock edges
    endtask
    // msb first, set while clock low, sampled at its rise
    task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            o_mosi = tx[7-i];
            #62.5;
            rx = {rx[6:0], i_miso_oe ? i_miso : ~i_miso};
            oe_seen = oe_seen | i_miso_oe;
            o_sclk = 1'b1;
            #62.5;
            o_sclk = 1'b0;
        end
    endtask
    // deselect after the last bit; released line shows no stale value
    task automatic desel();
        tick(8);
        o_cs_b = 1'b1;
        o_mosi = ~o_mosi;
        tick(8);
    endtask
endmodule // sfsr_host

/* sfsr_tb.sv */
// self-checking bench for the flash status and read block
`timescale 1ns/10ps
module testbench;
    import sfsr_pkg::*;
    localparam int WCYC = 1500;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic guard_b, ext_busy, ld_we;
    logic [9:0] ld_addr;
    logic [7:0] ld_data;
    logic cs_b, sclk, mosi, miso, oe, hard_protect_mode, wlf, be_ok;
    logic [7:0] status;
    logic [7:0] rxb [4];
    int n_fail = 0;
    int checks_done = 0;
    always #4 clk = ~clk;
    sfsr_top #(.WRITE_CYC(WCYC)) dut_u (.i_clk(clk), .i_rst_b(rst_b), .i_cs_b(cs_b),
        .i_sclk(sclk), .i_serial_in_line(mosi), .i_write_guard_pin_b(guard_b),
        .o_serial_out_line(miso), .o_serial_out_oe(oe), .i_ext_busy(ext_busy), .i_arr_we(ld_we),
        .i_arr_waddr(ld_addr), .i_arr_wdata(ld_data), .i_lock_we(ld_we),
        .i_lock_waddr(ld_addr[1:0]), .i_lock_wdata(ld_data), .o_status(status),
        .o_hard_protect_mode(hard_protect_mode), .o_bulk_erase_ok(be_ok), .o_write_latch_flag(wlf));
    sfsr_host host_u (.i_clk(clk), .o_cs_b(cs_b), .o_sclk(sclk), .o_mosi(mosi), .i_miso(miso),
        .i_miso_oe(oe));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // command, nh header bytes, nrx read bytes with nb bits in the last
    task automatic run(input logic [7:0] c, input logic [31:0] hdr, input int nh, input int nrx,
        input int nb);
        logic [7:0] rx;
        host_u.sel();
        host_u.shift(c, 8, rx);
        for (int i = 0; i < nh; i++) begin
            host_u.shift(hdr[8*(nh-1-i) +: 8], 8, rx);
        end
        for (int i = 0; i < nrx; i++) begin
            host_u.shift(8'h00, (i == nrx - 1) ? nb : 8, rx);
            rxb[i] = rx;
        end
        host_u.desel();
    endtask
    // poll busy under a bound
    task automatic wait_idle();
        int k = 0;
        while (status[0] !== 1'b0 && k < 2000) begin
            host_u.tick(1);
            k++;
        end
        if (k == 2000) begin
            chk(8'h01, 8'h00, "idle wait");
            conclude();
        end
    endtask
    // main sequence
    initial begin
        guard_b = 1'b1;
        ext_busy = 1'b0;
        ld_we = 1'b0;
        ld_addr = 10'h000;
        ld_data = 8'h00;
        host_u.tick(12);
        rst_b = 1'b1;
        chk(status, 8'h00, "status after reset");
        ld_we = 1'b1;
        for (int i = 0; i < 4; i++) begin
            ld_addr = 10'(i - 1);
            ld_data = 8'h5A + 8'(i) * 8'h31;
            host_u.tick(1);
        end
        ld_we = 1'b0;
        run(SFSR_CMD_READ, 32'hFFFFFF, 3, 3, 8);
        for (int i = 0; i < 3; i++) chk(rxb[i], 8'h5A + 8'(i) * 8'h31, "read wrap");
        run(SFSR_CMD_FAST, 32'h00000100, 4, 2, 8);
        for (int i = 0; i < 2; i++) chk(rxb[i], 8'h5A + 8'(i + 2) * 8'h31, "fast read");
        run(SFSR_CMD_RDLR, 32'h020000, 3, 2, 8);
        for (int i = 0; i < 2; i++) chk(rxb[i], 8'hED, "lock read");
        chk({7'h0, be_ok}, 8'h01, "bulk erase allowed");
        run(SFSR_CMD_READ, 32'h0, 3, 1, 3);
        chk({7'h0, oe}, 8'h00, "oe after abort");
        chk({7'h0, be_ok}, 8'h00, "bulk erase locked");
        run(SFSR_CMD_RDSR, 32'h0, 0, 2, 8);
        for (int i = 0; i < 2; i++) chk(rxb[i], 8'h00, "status poll");
        $display("test reads done");
        run(SFSR_CMD_WREN, 32'h0, 0, 0, 8);
        chk(status, 8'h02, "latch set");
        run(SFSR_CMD_WRSR, 32'hFF, 1, 0, 8);
        chk(status & 8'h03, 8'h03, "cycle started");
        run(SFSR_CMD_READ, 32'h0, 3, 1, 8);
        chk({7'h0, host_u.oe_seen}, 8'h00, "read while busy");
        run(SFSR_CMD_RDSR, 32'h0, 0, 1, 8);
        chk(rxb[0] & 8'h01, 8'h01, "busy bit read");
        wait_idle();
        chk(status, 8'h8C, "status written");
        run(SFSR_CMD_RDSR, 32'h0, 0, 2, 8);
        for (int i = 0; i < 2; i++) chk(rxb[i], 8'h8C, "status repeat");
        $display("test status write done");
        guard_b = 1'b0;
        host_u.tick(6);
        chk({7'h0, hard_protect_mode}, 8'h01, "hard protect on");
        run(SFSR_CMD_WREN, 32'h0, 0, 0, 8);
        run(SFSR_CMD_WRSR, 32'h00, 1, 0, 8);
        chk(status, 8'h8E, "write in hard protect");
        guard_b = 1'b1;
        host_u.tick(6);
        chk({7'h0, hard_protect_mode}, 8'h00, "hard protect off");
        run(SFSR_CMD_WRSR, 32'h00, 1, 0, 8);
        wait_idle();
        chk(status, 8'h00, "write after guard high");
        $display("test protection done");
        run(SFSR_CMD_WREN, 32'h0, 0, 1, 1);
        chk(status, 8'h00, "enable off boundary");
        run(SFSR_CMD_WRSR, 32'h0C, 1, 0, 8);
        chk(status, 8'h00, "write without latch");
        ext_busy = 1'b1;
        host_u.tick(4);
        chk(status, 8'h01, "external busy");
        ext_busy = 1'b0;
        host_u.tick(4);
        $display("test refusals done");
        conclude();
    end
endmodule // testbench
